// ### hw/t16_edge.sv
// Input edge detection for both timer pins and the main clock prescaler.
// Assumes the pins are already synchronous to clk.
`timescale 1ns/100ps
`include "t16_defines.svh"
module t16_edge (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Pins
    input  wire logic primary_timer_input,
    input  wire logic shared_secondary_input,
    // Core side
    t16_edge_if.unit  eif
);
    import t16_pkg::*;

    t16_edge_state_type s_q;
    t16_edge_state_type s_d;
    logic [3:0]         last_d;

    always_comb begin
        s_d = s_q;
        case (eif.clk_sel)
            `T16_CLK_DIV2:  last_d = `T16_DIV2_LAST;
            `T16_CLK_DIV4:  last_d = `T16_DIV4_LAST;
            default:        last_d = `T16_DIV16_LAST;
        endcase
        s_d.pri_last = primary_timer_input;
        s_d.sec_last = shared_secondary_input;
        s_d.pri_rise = primary_timer_input & ~s_q.pri_last;
        s_d.pri_fall = ~primary_timer_input & s_q.pri_last;
        s_d.sec_rise = shared_secondary_input & ~s_q.sec_last;
        s_d.sec_fall = ~shared_secondary_input & s_q.sec_last;
        // Divided main clock as a one-cycle enable
        if (s_q.div_cnt >= last_d) begin
            s_d.div_cnt  = `T16_DIV_ZERO;
            s_d.div_tick = 1'b1;
        end else begin
            s_d.div_cnt  = s_q.div_cnt + 4'h1;
            s_d.div_tick = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign eif.pri_rise = s_q.pri_rise;
    assign eif.pri_fall = s_q.pri_fall;
    assign eif.sec_rise = s_q.sec_rise;
    assign eif.sec_fall = s_q.sec_fall;
    assign eif.div_tick = s_q.div_tick;
endmodule

// ### hw/t16_timer.sv
// 16-bit timer/event counter with two capture/compare registers.
// Assumes a CPU register port synchronous to clk and synchronous pins.
`timescale 1ns/100ps
`include "t16_defines.svh"
module t16_timer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // CPU register port
    input  wire logic [15:0] cpu_addr,
    input  wire logic [15:0] cpu_wdata,
    input  wire logic [7:0]  cpu_bit_mask,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_word,
    input  wire logic        cpu_rd,
    output logic      [15:0] cpu_rdata,
    // Timer pins
    input  wire logic        primary_timer_input,
    input  wire logic        shared_secondary_input,
    // Interrupt requests
    output logic             compare_a_irq,
    output logic             compare_b_irq,
    output logic             remote_receive_irq
);
    import t16_pkg::*;

    t16_edge_if     eif ();
    t16_state_type  s_q;
    t16_state_type  s_d;
    t16_mode_type   mode;
    logic [7:0]     wmask;
    logic           wr_tmc;
    logic           wr_crc;
    logic           wr_prm;
    logic           wr_remote_receive_mode;
    logic           wr_word;
    logic           pri_valid;
    logic           sec_valid;
    logic           clr_valid;
    logic           src_tick;
    logic           want_tick;
    logic           read_count;
    logic           advance;
    logic           edge_clear;
    logic           changed;
    logic [15:0]    next_count;
    logic           cap_a;
    logic           cap_b;

    // Valid edge of a pin for a two-bit edge selector
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic       rise,
                                      input logic       fall);
        logic hit;
        hit = 1'b0;
        case (sel)
            `T16_EDGE_FALL: hit = fall;
            `T16_EDGE_RISE: hit = rise;
            `T16_EDGE_BOTH: hit = rise | fall;
            default:        hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Bit or byte write into a control byte
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] wdat,
                                         input logic [7:0] msk,
                                         input logic [7:0] wable);
        logic [7:0] m;
        m = msk & wable;
        return (old & ~m) | (wdat & m);
    endfunction

    t16_edge u_edge (
        .clk                    (clk),
        .rst_b                  (rst_b),
        .primary_timer_input    (primary_timer_input),
        .shared_secondary_input (shared_secondary_input),
        .eif                    (eif)
    );

    assign eif.clk_sel = s_q.prescaler_edge_select[`T16_PRM_CLK_HI:
                                                   `T16_PRM_CLK_LO];

    always_comb begin
        s_d = s_q;
        wmask = cpu_word ? 8'(`T16_WORD_MAX) : cpu_bit_mask;
        wr_tmc  = 1'b0;
        wr_crc  = 1'b0;
        wr_prm  = 1'b0;
        wr_remote_receive_mode = 1'b0;
        wr_word = cpu_wr & cpu_word;

        // Control register writes, bit or byte wide
        if (cpu_wr && cpu_addr == `T16_ADDR_TMC) begin
            wr_tmc = 1'b1;
        end else if (cpu_wr && cpu_addr == `T16_ADDR_CRC) begin
            wr_crc = 1'b1;
        end else if (cpu_wr && cpu_addr == `T16_ADDR_PRM) begin
            wr_prm = 1'b1;
        end else if (cpu_wr && cpu_addr == `T16_ADDR_REMOTE_RECEIVE_MODE) begin
            wr_remote_receive_mode = 1'b1;
        end
        if (wr_tmc) begin
            s_d.timer_mode_control = merge(s_q.timer_mode_control,
                cpu_wdata[7:0], wmask, `T16_TMC_WMASK);
        end
        if (wr_crc) begin
            s_d.capture_compare_control = merge(s_q.capture_compare_control,
                cpu_wdata[7:0], wmask, `T16_CRC_WMASK);
        end
        if (wr_prm) begin
            s_d.prescaler_edge_select = merge(s_q.prescaler_edge_select,
                cpu_wdata[7:0], wmask, `T16_PRM_WMASK);
        end
        if (wr_remote_receive_mode) begin
            s_d.remote_receive_mode = merge(s_q.remote_receive_mode,
                cpu_wdata[7:0], wmask, `T16_REMOTE_RECEIVE_MODE_WMASK);
        end

        // Word registers accept only full 16-bit writes
        if (wr_word && cpu_addr == `T16_ADDR_CCA) begin
            s_d.capture_compare_a = cpu_wdata;
        end else if (wr_word && cpu_addr == `T16_ADDR_CCB) begin
            s_d.capture_compare_b = cpu_wdata;
        end else if (wr_word && cpu_addr == `T16_ADDR_RMIN) begin
            s_d.remote_min = cpu_wdata;
        end else if (wr_word && cpu_addr == `T16_ADDR_RMAX) begin
            s_d.remote_max = cpu_wdata;
        end

        // New mode takes effect at once, so a stop write clears the count
        mode = t16_mode_type'(s_d.timer_mode_control[`T16_TMC_MODE_HI:
                                                     `T16_TMC_MODE_LO]);

        // Edge qualification
        pri_valid = edge_hit(
            s_q.prescaler_edge_select[`T16_PRM_PRI_HI:`T16_PRM_PRI_LO],
            eif.pri_rise, eif.pri_fall);
        sec_valid = edge_hit(
            s_q.prescaler_edge_select[`T16_PRM_SEC_HI:`T16_PRM_SEC_LO],
            eif.sec_rise, eif.sec_fall);
        if (s_q.remote_receive_mode[`T16_REMOTE_RECEIVE_MODE_ENA]) begin
            case (s_q.remote_receive_mode[`T16_REMOTE_RECEIVE_MODE_CLR_HI:
                                          `T16_REMOTE_RECEIVE_MODE_CLR_LO])
                `T16_REM_FALL: clr_valid = eif.pri_fall;
                `T16_REM_RISE: clr_valid = eif.pri_rise;
                default:       clr_valid = 1'b0;
            endcase
        end else begin
            clr_valid = pri_valid;
        end

        // Count clock source
        if (eif.clk_sel == `T16_CLK_EDGE) begin
            src_tick = pri_valid;
        end else begin
            src_tick = eif.div_tick;
        end

        // A read of the count defers the tick by one cycle
        read_count = cpu_rd && cpu_addr == `T16_ADDR_COUNT;
        want_tick  = (mode != T16_MODE_STOP) && (src_tick || s_q.tick_held);
        advance    = want_tick && !read_count;
        s_d.tick_held = want_tick && read_count;
        edge_clear = (mode == T16_MODE_EDGE_CLR) && clr_valid;

        // Count update
        if (mode == T16_MODE_STOP) begin
            next_count = `T16_RST_WORD;
        end else if (edge_clear) begin
            next_count = `T16_RST_WORD;
        end else if (advance && mode == T16_MODE_MATCH_CLR &&
                     s_q.count_value == s_q.capture_compare_a) begin
            next_count = `T16_RST_WORD;
        end else if (advance) begin
            next_count = s_q.count_value + `T16_COUNT_ONE;
        end else begin
            next_count = s_q.count_value;
        end
        s_d.count_value = next_count;
        changed = (mode != T16_MODE_STOP) && (advance || edge_clear);

        // Overflow on wrap; the set beats a simultaneous clear
        if (advance && !edge_clear &&
            s_q.count_value == `T16_WORD_MAX) begin
            s_d.timer_mode_control[`T16_TMC_OVF] = 1'b1;
        end

        // Compare requests, one pulse when the count arrives at the value
        s_d.compare_a_irq = changed &&
            !s_q.capture_compare_control[`T16_CRC_ROLE_A] &&
            next_count == s_q.capture_compare_a;
        s_d.compare_b_irq = changed &&
            !s_q.capture_compare_control[`T16_CRC_ROLE_B] &&
            next_count == s_q.capture_compare_b;

        // Capture into A: opposite primary edge or selected secondary edge
        if (s_q.capture_compare_control[`T16_CRC_TRIG_A]) begin
            case (s_q.prescaler_edge_select[`T16_PRM_PRI_HI:
                                            `T16_PRM_PRI_LO])
                `T16_EDGE_FALL: cap_a = eif.pri_rise;
                `T16_EDGE_RISE: cap_a = eif.pri_fall;
                default:        cap_a = 1'b0;
            endcase
        end else begin
            cap_a = sec_valid;
        end
        cap_a = cap_a && s_q.capture_compare_control[`T16_CRC_ROLE_A];
        cap_b = pri_valid &&
            s_q.capture_compare_control[`T16_CRC_ROLE_B];
        // A capture outranks a software write in the same cycle
        if (cap_a) begin
            s_d.capture_compare_a = s_q.count_value;
        end
        if (cap_b) begin
            s_d.capture_compare_b = s_q.count_value;
        end

        // Remote receive: width at the clear edge checked against limits
        s_d.remote_receive_irq = edge_clear &&
            s_q.remote_receive_mode[`T16_REMOTE_RECEIVE_MODE_ENA] &&
            s_q.count_value >= s_q.remote_min &&
            s_q.count_value <= s_q.remote_max;

        // Registered read data; unmapped addresses read zero
        if (!cpu_rd) begin
            s_d.rdata = s_q.rdata;
        end else if (cpu_addr == `T16_ADDR_COUNT) begin
            s_d.rdata = s_q.count_value;
        end else if (cpu_addr == `T16_ADDR_CCA) begin
            s_d.rdata = s_q.capture_compare_a;
        end else if (cpu_addr == `T16_ADDR_CCB) begin
            s_d.rdata = s_q.capture_compare_b;
        end else if (cpu_addr == `T16_ADDR_TMC) begin
            s_d.rdata = {8'h00, s_q.timer_mode_control};
        end else if (cpu_addr == `T16_ADDR_CRC) begin
            s_d.rdata = {8'h00, s_q.capture_compare_control};
        end else if (cpu_addr == `T16_ADDR_PRM) begin
            s_d.rdata = {8'h00, s_q.prescaler_edge_select};
        end else if (cpu_addr == `T16_ADDR_REMOTE_RECEIVE_MODE) begin
            s_d.rdata = {8'h00, s_q.remote_receive_mode};
        end else if (cpu_addr == `T16_ADDR_RMIN) begin
            s_d.rdata = s_q.remote_min;
        end else if (cpu_addr == `T16_ADDR_RMAX) begin
            s_d.rdata = s_q.remote_max;
        end else begin
            s_d.rdata = `T16_RST_WORD;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cpu_rdata          = s_q.rdata;
    assign compare_a_irq      = s_q.compare_a_irq;
    assign compare_b_irq      = s_q.compare_b_irq;
    assign remote_receive_irq = s_q.remote_receive_irq;
endmodule

// ### inc/t16_defines.svh
// Constants of the 16-bit timer/event counter: addresses, fields, codes.
// Assumes a 16-bit CPU address space and a byte-wide control register set.
`ifndef T16_DEFINES_SVH
`define T16_DEFINES_SVH

// Register addresses
`define T16_ADDR_COUNT      16'hFF10
`define T16_ADDR_CCA        16'hFF12
`define T16_ADDR_CCB        16'hFF14
`define T16_ADDR_TMC        16'hFF18
`define T16_ADDR_CRC        16'hFF1A
`define T16_ADDR_PRM        16'hFF1C
`define T16_ADDR_REMOTE_RECEIVE_MODE       16'hFF1E
`define T16_ADDR_RMIN       16'hFF20
`define T16_ADDR_RMAX       16'hFF22

// Reset values and word constants
`define T16_RST_BYTE        8'h00
`define T16_RST_WORD        16'h0000
`define T16_WORD_MAX        16'hFFFF
`define T16_COUNT_ONE       16'h0001

// Writable bit masks
`define T16_TMC_WMASK       8'h0D
`define T16_CRC_WMASK       8'h07
`define T16_PRM_WMASK       8'hF3
`define T16_REMOTE_RECEIVE_MODE_WMASK      8'hF3

// Field positions
`define T16_TMC_OVF         0
`define T16_TMC_MODE_LO     2
`define T16_TMC_MODE_HI     3
`define T16_CRC_ROLE_A      0
`define T16_CRC_TRIG_A      1
`define T16_CRC_ROLE_B      2
`define T16_PRM_CLK_LO      0
`define T16_PRM_CLK_HI      1
`define T16_PRM_PRI_LO      4
`define T16_PRM_PRI_HI      5
`define T16_PRM_SEC_LO      6
`define T16_PRM_SEC_HI      7
`define T16_REMOTE_RECEIVE_MODE_ENA        1
`define T16_REMOTE_RECEIVE_MODE_CLR_LO     4
`define T16_REMOTE_RECEIVE_MODE_CLR_HI     5

// Edge selection codes
`define T16_EDGE_FALL       2'h0
`define T16_EDGE_RISE       2'h1
`define T16_EDGE_BAD        2'h2
`define T16_EDGE_BOTH       2'h3
`define T16_REM_NONE        2'h0
`define T16_REM_FALL        2'h1
`define T16_REM_RISE        2'h2

// Count clock selection codes and last prescaler counts
`define T16_CLK_DIV2        2'h0
`define T16_CLK_DIV4        2'h1
`define T16_CLK_DIV16       2'h2
`define T16_CLK_EDGE        2'h3
`define T16_DIV2_LAST       4'h1
`define T16_DIV4_LAST       4'h3
`define T16_DIV16_LAST      4'hF
`define T16_DIV_ZERO        4'h0

`endif

// ### inc/t16_edge_if.sv
// Carrier between the counter core and its input edge / prescaler unit.
// Assumes both ends share clk and rst_b.
`timescale 1ns/100ps
interface t16_edge_if;
    logic [1:0] clk_sel;
    logic       pri_rise;
    logic       pri_fall;
    logic       sec_rise;
    logic       sec_fall;
    logic       div_tick;

    modport core (
        output clk_sel,
        input  pri_rise,
        input  pri_fall,
        input  sec_rise,
        input  sec_fall,
        input  div_tick
    );

    modport unit (
        input  clk_sel,
        output pri_rise,
        output pri_fall,
        output sec_rise,
        output sec_fall,
        output div_tick
    );
endinterface

// ### inc/t16_pkg.sv
// Types shared by the timer/event counter modules.
// Assumes t16_defines.svh is on the include path.
package t16_pkg;

    typedef enum logic [1:0] {
        T16_MODE_STOP,
        T16_MODE_FREE,
        T16_MODE_EDGE_CLR,
        T16_MODE_MATCH_CLR
    } t16_mode_type;

    typedef struct packed {
        logic [7:0]  timer_mode_control;
        logic [7:0]  capture_compare_control;
        logic [7:0]  prescaler_edge_select;
        logic [7:0]  remote_receive_mode;
        logic [15:0] count_value;
        logic [15:0] capture_compare_a;
        logic [15:0] capture_compare_b;
        logic [15:0] remote_min;
        logic [15:0] remote_max;
        logic        tick_held;
        logic [15:0] rdata;
        logic        compare_a_irq;
        logic        compare_b_irq;
        logic        remote_receive_irq;
    } t16_state_type;

    typedef struct packed {
        logic [3:0] div_cnt;
        logic       pri_last;
        logic       sec_last;
        logic       pri_rise;
        logic       pri_fall;
        logic       sec_rise;
        logic       sec_fall;
        logic       div_tick;
    } t16_edge_state_type;

endpackage

// ### tb/t16_pin_src.sv
// Behavioural source of the primary and secondary timer input pins.
// Assumes its tasks are called from a falling edge of clk.
`timescale 1ns/100ps
module t16_pin_src (
    // Clock
    input wire logic clk,
    // Pins
    output logic     primary_timer_input,
    output logic     shared_secondary_input
);
    initial begin
        primary_timer_input = 1'b0;
        shared_secondary_input = 1'b0;
    end

    // A level is held for hold_cyc clocks; callers keep it over three count
    // clocks when a capture depends on it
    task automatic set_pri(input logic lvl, input int hold_cyc);
        primary_timer_input = lvl;
        repeat (hold_cyc) @(negedge clk);
    endtask

    task automatic set_sec(input logic lvl, input int hold_cyc);
        shared_secondary_input = lvl;
        repeat (hold_cyc) @(negedge clk);
    endtask
endmodule

// ### tb/t16_timer_chk.sv
// Port-level checker for the 16-bit timer/event counter.
// Assumes it is bound to t16_timer and sees only that module's ports.
`timescale 1ns/100ps
`include "t16_defines.svh"
module t16_timer_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // CPU register port
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    input wire logic [7:0]  cpu_bit_mask,
    input wire logic        cpu_wr,
    input wire logic        cpu_word,
    input wire logic        cpu_rd,
    input wire logic [15:0] cpu_rdata,
    // Timer pins
    input wire logic        primary_timer_input,
    input wire logic        shared_secondary_input,
    // Interrupt requests
    input wire logic        compare_a_irq,
    input wire logic        compare_b_irq,
    input wire logic        remote_receive_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_irqa_pulse: assert property (compare_a_irq |=> !compare_a_irq)
        else $error("compare A request wider than one cycle");
    a_irqb_pulse: assert property (compare_b_irq |=> !compare_b_irq)
        else $error("compare B request wider than one cycle");
    a_irqr_pulse: assert property (remote_receive_irq |=> !remote_receive_irq)
        else $error("remote request wider than one cycle");
    a_rdata_hold: assert property (!cpu_rd |=> $stable(cpu_rdata))
        else $error("read data moved without a read");
    a_stop_zero: assert property (
        cpu_wr && cpu_addr == `T16_ADDR_TMC && cpu_bit_mask == 8'hFF
        && cpu_wdata[3:2] == 2'h0 ##1 cpu_rd && cpu_addr == `T16_ADDR_COUNT
        |=> cpu_rdata == 16'h0000)
        else $error("count not cleared by stop mode");
    a_mode_readback: assert property (
        cpu_wr && cpu_addr == `T16_ADDR_TMC && cpu_bit_mask == 8'hFF
        ##1 cpu_rd && cpu_addr == `T16_ADDR_TMC
        |=> (cpu_rdata & 16'h000C) == ($past(cpu_wdata, 2) & 16'h000C))
        else $error("mode field does not read back");
    a_tmc_spare: assert property (
        cpu_rd && cpu_addr == `T16_ADDR_TMC |=> (cpu_rdata & 16'hFFF2) == 0)
        else $error("spare mode register bits not zero");
    a_cca_word: assert property (
        cpu_wr && cpu_word && cpu_addr == `T16_ADDR_CCA
        ##1 cpu_rd && cpu_addr == `T16_ADDR_CCA
        |=> cpu_rdata == $past(cpu_wdata, 2))
        else $error("register A word write lost");
    a_ccb_word: assert property (
        cpu_wr && cpu_word && cpu_addr == `T16_ADDR_CCB
        ##1 cpu_rd && cpu_addr == `T16_ADDR_CCB
        |=> cpu_rdata == $past(cpu_wdata, 2))
        else $error("register B word write lost");

    c_irq_a: cover property (compare_a_irq);
    c_irq_b: cover property (compare_b_irq);
    c_count_rd: cover property (cpu_rd && cpu_addr == `T16_ADDR_COUNT);
endmodule

// ### tb/tb.sv
// Self-checking bench of the 16-bit timer/event counter.
// Assumes t16_timer, the pin source and the checker are compiled first.
`timescale 1ns/100ps
`include "t16_defines.svh"
module tb;
    logic        clk;
    logic        rst_b;
    logic [15:0] cpu_addr;
    logic [15:0] cpu_wdata;
    logic [7:0]  cpu_bit_mask;
    logic        cpu_wr;
    logic        cpu_word;
    logic        cpu_rd;
    logic [15:0] cpu_rdata;
    logic        pri_pin;
    logic        sec_pin;
    logic        irq_a;
    logic        irq_b;
    logic        irq_rem;
    int          fail_count;
    int          comparisons;

    t16_timer DUT (.clk(clk), .rst_b(rst_b), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_bit_mask(cpu_bit_mask), .cpu_wr(cpu_wr),
        .cpu_word(cpu_word), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
        .primary_timer_input(pri_pin), .shared_secondary_input(sec_pin),
        .compare_a_irq(irq_a), .compare_b_irq(irq_b),
        .remote_receive_irq(irq_rem));
    t16_pin_src u_src (.clk(clk), .primary_timer_input(pri_pin),
        .shared_secondary_input(sec_pin));

    always #20 clk = ~clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Strobes are dropped and a clock passes, so no strobe is reasserted
    // in the time step that lowered it
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clk);
        cpu_rd = 1'b0;
        d = cpu_rdata;
        @(negedge clk);
    endtask

    task automatic wr_rd(input logic [15:0] a, input logic [15:0] d,
                         input logic [7:0] m, input logic w,
                         input logic [15:0] ra, output logic [15:0] v);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_bit_mask = m;
        cpu_word = w;
        cpu_wr = 1'b1;
        @(negedge clk);
        cpu_wr = 1'b0;
        rd(ra, v);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d,
                      input logic w);
        logic [15:0] v;
        wr_rd(a, d, 8'hFF, w, 16'hFF16, v);
    endtask

    task automatic wait_irq(input logic b, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((b ? irq_b : irq_a) !== 1'b1 && n < 300);
        if (n >= 300) begin
            fail_count++;
            $display("Timeout waiting for a compare request");
            test_done();
        end
    endtask

    task automatic t_reset;
        logic [15:0] adr [8] = '{`T16_ADDR_COUNT, `T16_ADDR_CCA, `T16_ADDR_CCB,
            `T16_ADDR_TMC, `T16_ADDR_CRC, `T16_ADDR_PRM, `T16_ADDR_REMOTE_RECEIVE_MODE,
            16'hFF16};
        logic [15:0] v;
        foreach (adr[i]) begin
            rd(adr[i], v);
            check(v, `T16_RST_WORD);
        end
        $display("Test reset values done");
    endtask

    task automatic t_mode;
        logic [15:0] v;
        wr_rd(`T16_ADDR_TMC, 16'h00FF, 8'hFF, 1'b0, `T16_ADDR_TMC, v);
        check(v, 16'h000D);
        wr_rd(`T16_ADDR_TMC, 16'h0000, 8'hFF, 1'b0, `T16_ADDR_COUNT, v);
        check(v, 16'h0000);
        wr_rd(`T16_ADDR_TMC, 16'h0001, 8'h01, 1'b0, `T16_ADDR_TMC, v);
        check(v, 16'h0001);
        wr_rd(`T16_ADDR_TMC, 16'h0000, 8'h01, 1'b0, `T16_ADDR_TMC, v);
        check(v, 16'h0000);
        wr_rd(`T16_ADDR_TMC, 16'h0008, 8'hFF, 1'b0, `T16_ADDR_TMC, v);
        check(v, 16'h0008);
        wr(`T16_ADDR_TMC, 16'h0000, 1'b0);
        wr_rd(`T16_ADDR_CCA, 16'h1234, 8'hFF, 1'b1, `T16_ADDR_CCA, v);
        check(v, 16'h1234);
        wr_rd(`T16_ADDR_CCA, 16'h5678, 8'hFF, 1'b0, `T16_ADDR_CCA, v);
        check(v, 16'h1234);
        wr_rd(`T16_ADDR_CCB, 16'h9ABC, 8'hFF, 1'b1, `T16_ADDR_CCB, v);
        check(v, 16'h9ABC);
        $display("Test mode register done");
    endtask

    task automatic t_interval;
        logic [1:0] sel [3] = '{`T16_CLK_DIV2, `T16_CLK_DIV4, `T16_CLK_DIV16};
        int div [3] = '{2, 4, 16};
        int n;
        foreach (sel[i]) begin
            wr(`T16_ADDR_TMC, 16'h0000, 1'b0);
            wr(`T16_ADDR_PRM, {14'h0000, sel[i]}, 1'b0);
            wr(`T16_ADDR_CCA, 16'h0003, 1'b1);
            wr(`T16_ADDR_CCB, 16'h0002, 1'b1);
            wr(`T16_ADDR_TMC, 16'h000C, 1'b0);
            wait_irq(1'b0, n);
            wait_irq(1'b0, n);
            check(n[15:0], 16'(4 * div[i]));
            wait_irq(1'b1, n);
            wait_irq(1'b1, n);
            check(n[15:0], 16'(4 * div[i]));
        end
        $display("Test interval timer done");
    endtask

    task automatic t_events;
        logic [1:0] code [4] = '{`T16_EDGE_FALL, `T16_EDGE_RISE,
            `T16_EDGE_BAD, `T16_EDGE_BOTH};
        logic [15:0] exp [4] = '{16'h0005, 16'h0005, 16'h0000, 16'h000A};
        logic [15:0] v;
        foreach (code[i]) begin
            wr(`T16_ADDR_TMC, 16'h0000, 1'b0);
            wr(`T16_ADDR_PRM, {10'h000, code[i], 2'h0, `T16_CLK_EDGE}, 1'b0);
            wr(`T16_ADDR_TMC, 16'h0004, 1'b0);
            repeat (5) begin
                u_src.set_pri(1'b1, 4);
                u_src.set_pri(1'b0, 4);
            end
            rd(`T16_ADDR_COUNT, v);
            check(v, exp[i]);
        end
        $display("Test event counting done");
    endtask

    task automatic t_capture;
        logic [7:0] crc [4] = '{8'h01, 8'h03, 8'h03, 8'h04};
        logic [7:0] prm [4] = '{8'h40, 8'h00, 8'h30, 8'h10};
        logic       sec [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
        logic       hit [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        logic [15:0] r0;
        logic [15:0] r1;
        logic [15:0] v;
        logic        ok;
        foreach (crc[i]) begin
            wr(`T16_ADDR_TMC, 16'h0000, 1'b0);
            wr(`T16_ADDR_CRC, {8'h00, crc[i]}, 1'b0);
            wr(`T16_ADDR_PRM, {8'h00, prm[i]}, 1'b0);
            wr(`T16_ADDR_CCA, 16'hFFF0, 1'b1);
            wr(`T16_ADDR_CCB, 16'hFFF0, 1'b1);
            wr(`T16_ADDR_TMC, 16'h0004, 1'b0);
            rd(`T16_ADDR_COUNT, r0);
            if (sec[i])
                u_src.set_sec(1'b1, 6);
            else
                u_src.set_pri(1'b1, 6);
            rd(`T16_ADDR_COUNT, r1);
            rd(crc[i][2] ? `T16_ADDR_CCB : `T16_ADDR_CCA, v);
            ok = hit[i] ? (v >= r0 && v <= r1) : (v === 16'hFFF0);
            check({15'h0000, ok}, 16'h0001);
            u_src.set_sec(1'b0, 6);
            u_src.set_pri(1'b0, 6);
        end
        $display("Test capture done");
    endtask

    // Widths inside and outside the limits; clear edge is the falling one
    task automatic t_remote;
        logic [15:0] lim [2] = '{16'h0100, 16'h0002};
        logic [15:0] exp [2] = '{16'h0001, 16'h0000};
        logic [15:0] n;
        wr(`T16_ADDR_TMC, 16'h0000, 1'b0);
        wr(`T16_ADDR_PRM, 16'h0000, 1'b0);
        wr(`T16_ADDR_REMOTE_RECEIVE_MODE, 16'h0012, 1'b0);
        wr(`T16_ADDR_RMIN, 16'h0001, 1'b1);
        wr(`T16_ADDR_TMC, 16'h0008, 1'b0);
        foreach (lim[i]) begin
            wr(`T16_ADDR_RMAX, lim[i], 1'b1);
            n = 16'h0000;
            u_src.set_pri(1'b1, 20);
            u_src.set_pri(1'b0, 0);
            repeat (6) begin
                @(negedge clk);
                n = n + {15'h0000, irq_rem};
            end
            check(n, exp[i]);
        end
        wr(`T16_ADDR_REMOTE_RECEIVE_MODE, 16'h0000, 1'b0);
        $display("Test remote receive done");
    endtask

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        cpu_addr = 16'h0000;
        cpu_wdata = 16'h0000;
        cpu_bit_mask = 8'h00;
        cpu_wr = 1'b0;
        cpu_word = 1'b0;
        cpu_rd = 1'b0;
        fail_count = 0;
        comparisons = 0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_reset();
        t_mode();
        t_interval();
        t_events();
        t_capture();
        t_remote();
        test_done();
    end
endmodule

bind t16_timer t16_timer_chk u_chk (.clk(clk), .rst_b(rst_b),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_bit_mask(cpu_bit_mask),
    .cpu_wr(cpu_wr), .cpu_word(cpu_word), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .primary_timer_input(primary_timer_input),
    .shared_secondary_input(shared_secondary_input),
    .compare_a_irq(compare_a_irq), .compare_b_irq(compare_b_irq),
    .remote_receive_irq(remote_receive_irq));
